// File: psfa_fp_if.sv
// Purpose: carrier between the main block and the aliased fp register array
// Assumes: single clock
// Notes:   one write port, one read port
`timescale 1ns/10ps
`default_nettype none
interface psfa_fp_if;
	import psfa_pkg::*;
	logic                wrEn;
	logic [2:0]          wrIdx;
	logic [REG_BITS-1:0] wrMant;
	logic [2:0]          rdIdx;
	logic [FP_BITS-1:0]  rdEntry;
	modport ctrl (output wrEn, wrIdx, wrMant, rdIdx, input rdEntry);
	modport store (input wrEn, wrIdx, wrMant, rdIdx, output rdEntry);
endinterface
`default_nettype wire

// File: psfa_fp_store.sv
// Purpose: eight 80-bit fp entries shared with the packed registers
// Assumes: writes come from packed instructions only
// Notes:   mantissa in low 64 bits, exponent above it
`timescale 1ns/10ps
`default_nettype none
module psfa_fp_store (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// access
	psfa_fp_if.store fp
);
	import psfa_pkg::*;
	logic [FP_BITS-1:0] entry_q [NUM_REGS];

	// one entry per register
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_ent
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				entry_q[i] <= '0;
			end else if (fp.wrEn && fp.wrIdx == 3'(i)) begin
				entry_q[i] <= {1'b0, EXP_ONES, fp.wrMant}; // [RULE_04] [RULE_13]
			end
		end
	end

	assign fp.rdEntry = entry_q[fp.rdIdx]; // [RULE_01]

	stored_exp_a: assert property (@(posedge clk) disable iff (rst)
		fp.wrEn |=> entry_q[$past(fp.wrIdx)][FP_BITS-2 -: EXP_BITS] == EXP_ONES) // [RULE_04]
		else $error("exponent not all ones after packed write");
endmodule
`default_nettype wire

// File: psfa_pipe_model.sv
// Purpose: instruction pipeline model on the far side of the register block
// Assumes: one instruction per issue call, two per issue_pair call, answer registered on the edge that takes it
// Notes:   released reg lines show the inverse of their last value, as do data and vector lines after issue; valid and memFault drop to zero
`timescale 1ns/10ps
`default_nettype none
module psfa_pipe_model (
	// clock
	input  wire logic                  clk,
	// instruction port
	output var logic                   instrValid,
	output var psfa_pkg::psfa_op_type  instrOp,
	output var logic [2:0]             instrReg,
	output var logic [63:0]            instrData,
	output var logic                   memFault,
	output var logic [7:0]             memFaultVec
);
	import psfa_pkg::*;
	initial begin
		instrValid = 1'b0;
		instrOp = PSFA_OP_OTHER;
		instrReg = 3'h0;
		instrData = 64'h0;
		memFault = 1'b0;
		memFaultVec = 8'h0;
	end
	////////////////////////////////////////////////////////////////
	// one instruction, held for its taking edge only
	task automatic issue(input psfa_op_type op, input logic [2:0] r, input logic [63:0] d,
		input logic f, input logic [7:0] v);
		@(posedge clk);
		instrValid <= 1'b1;
		instrOp <= op;
		instrReg <= r;
		instrData <= d;
		memFault <= f;
		memFaultVec <= v;
		@(posedge clk);
		instrValid <= 1'b0;
		instrReg <= ~r;
		instrData <= ~d;
		memFault <= 1'b0;
		memFaultVec <= ~v;
		#1;
	endtask
	// write then read of one register on consecutive edges
	task automatic issue_pair(input logic [2:0] r, input logic [63:0] d);
		@(posedge clk);
		instrValid <= 1'b1;
		instrOp <= PSFA_OP_WRITE;
		instrReg <= r;
		instrData <= d;
		memFault <= 1'b0;
		@(posedge clk);
		instrOp <= PSFA_OP_READ;
		instrData <= ~d;
		@(posedge clk);
		instrValid <= 1'b0;
		instrReg <= ~r;
		#1;
	endtask
endmodule
`default_nettype wire

// File: psfa_pkg.sv
// Purpose: shared constants and types for the packed simd / fp alias register block
// Assumes: axi4-lite register bus, 32-bit data
// Notes:   byte offsets are word aligned
package psfa_pkg;
	localparam int          NUM_REGS     = 8;
	localparam int          REG_BITS     = 64;
	localparam int          EXP_BITS     = 15;
	localparam int          FP_BITS      = 80;
	localparam int          TAG_BITS     = 16;
	localparam logic [15:0] TAG_VALID    = 16'h0000;
	localparam logic [15:0] TAG_EMPTY    = 16'hffff;
	localparam logic [14:0] EXP_ONES     = 15'h7fff;
	localparam logic [2:0]  TOP_ZERO     = 3'h0;
	localparam logic [7:0]  VEC_NUMERIC  = 8'h10;
	localparam logic [7:0]  VEC_INVALID  = 8'h06;
	localparam logic [7:0]  VEC_NONE     = 8'h00;
	// register byte offsets
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_STATUS   = 8'h04;
	localparam logic [7:0]  OFF_TAG      = 8'h08;
	localparam logic [7:0]  OFF_SEL      = 8'h0c;
	localparam logic [7:0]  OFF_DLO      = 8'h10;
	localparam logic [7:0]  OFF_DHI      = 8'h14;
	localparam logic [7:0]  OFF_EXP      = 8'h18;
	// control bit positions
	localparam int          CTRL_EMUL    = 0;
	localparam int          CTRL_FPPEND  = 1;
	// status bit positions
	localparam int          ST_TOP_LSB   = 11;
	localparam int          ST_PEND      = 16;
	localparam int          ST_ERR       = 17;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
	typedef enum logic [1:0] {PSFA_OP_WRITE, PSFA_OP_READ, PSFA_OP_EMPTY, PSFA_OP_OTHER} psfa_op_type;
endpackage

// File: psfa_regs.sv
// Purpose: packed simd register state aliased on fp registers and tags
// Assumes: pipeline presents one instruction per cycle on instrValid
// Notes:   software view over axi4-lite
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [RULE_01] packed registers share fp register storage
// [RULE_02] registers addressed directly by index
// [RULE_03] stack top forced zero after instruction
// [RULE_04] packed write sets exponent to ones
// [RULE_05] non-empty instruction sets all tags valid
// [RULE_06] empty-state instruction sets all tags empty
// [RULE_07] no numeric fault unless fp pending
// [RULE_08] pending fp error faults next instruction
// [RULE_09] faulting instruction restarts after handler
// [RULE_10] memory faults reported as usual
// [RULE_11] emulation bit makes instruction invalid opcode
// [RULE_12] software empties state when done
// [RULE_13] eight 64-bit registers in mantissas
module psfa_regs (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// instruction port
	input  wire logic                     instrValid,
	input  wire psfa_pkg::psfa_op_type    instrOp,
	input  wire logic [2:0]               instrReg,
	input  wire logic [63:0]              instrData,
	input  wire logic                     memFault,
	input  wire logic [7:0]               memFaultVec,
	// instruction results
	output logic                          doneValid,
	output logic [63:0]                   rdData,
	output logic                          excValid,
	output logic [7:0]                    excVector,
	output logic                          fpErrOut,
	output logic [2:0]                    stackTop,
	output logic [15:0]                   tagWord,
	// axi4-lite
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);
	import psfa_pkg::*;

	psfa_fp_if fp ();
	psfa_fp_store u_store (
		.clk (clk),
		.rst (rst),
		.fp  (fp.store)
	);

	logic          emul_q;
	logic          pend_q;
	logic [2:0]    sel_q;
	logic          awHeld_q;
	logic          wHeld_q;
	logic [7:0]    awAddr_q;
	logic [31:0]   wData_q;
	logic [3:0]    wStrb_q;
	logic          pendSet;
	logic          fault;

	////////////////////////////////////////////////////////////////////////
	// instruction qualification
	assign fault   = instrValid && (emul_q || pend_q || memFault);
	assign pendSet = awHeld_q && wHeld_q && awAddr_q == OFF_CTRL && wStrb_q[0] && wData_q[CTRL_FPPEND];

	always_comb begin
		fp.wrEn   = instrValid && !fault && instrOp == PSFA_OP_WRITE;
		fp.wrIdx  = instrReg; // [RULE_02]
		fp.wrMant = instrData;
		fp.rdIdx  = (instrValid && instrOp == PSFA_OP_READ) ? instrReg : sel_q;
	end

	////////////////////////////////////////////////////////////////////////
	// instruction results
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			doneValid <= 1'b0;
			excValid  <= 1'b0;
			excVector <= VEC_NONE;
			rdData    <= '0;
		end else begin
			doneValid <= instrValid && !fault;
			excValid  <= fault;
			rdData    <= fp.rdEntry[REG_BITS-1:0]; // [RULE_01]
			if (!instrValid) begin
				excVector <= VEC_NONE;
			end else if (emul_q) begin
				excVector <= VEC_INVALID; // [RULE_11]
			end else if (memFault) begin
				excVector <= memFaultVec; // [RULE_10]
			end else if (pend_q) begin
				excVector <= VEC_NUMERIC; // [RULE_08] [RULE_07]
			end else begin
				excVector <= VEC_NONE;
			end
		end
	end

	// fault error pin follows pending state seen by an instruction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fpErrOut <= 1'b0;
		end else if (instrValid && !emul_q && !memFault && pend_q) begin
			fpErrOut <= 1'b1; // [RULE_08]
		end else if (!pend_q) begin
			fpErrOut <= 1'b0;
		end
	end

	// pending fp exception, set from fp side via register, cleared by handler
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
		end else if (pendSet) begin
			pend_q <= 1'b1;
		end else if (awHeld_q && wHeld_q && awAddr_q == OFF_CTRL && wStrb_q[0]) begin
			pend_q <= 1'b0; // [RULE_09]
		end
	end

	// fp state side effects
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stackTop <= TOP_ZERO;
			tagWord  <= TAG_EMPTY;
		end else if (instrValid && !fault) begin
			stackTop <= TOP_ZERO; // [RULE_03]
			if (instrOp == PSFA_OP_EMPTY) begin
				tagWord <= TAG_EMPTY; // [RULE_06]
			end else begin
				tagWord <= TAG_VALID; // [RULE_05]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else if (awHeld_q && wHeld_q) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !wHeld_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			emul_q <= 1'b0;
			sel_q  <= '0;
		end else if (awHeld_q && wHeld_q) begin
			if (awAddr_q == OFF_CTRL && wStrb_q[0]) begin
				emul_q <= wData_q[CTRL_EMUL];
			end else if (awAddr_q == OFF_SEL && wStrb_q[0]) begin
				sel_q <= wData_q[2:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (awHeld_q && wHeld_q) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awAddr_q == OFF_CTRL || awAddr_q == OFF_SEL) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			if (s_axi_araddr == OFF_CTRL) begin
				s_axi_rdata <= {30'h0, pend_q, emul_q};
			end else if (s_axi_araddr == OFF_STATUS) begin
				s_axi_rdata <= {14'h0, fpErrOut, pend_q, 2'h0, stackTop, 11'h0};
			end else if (s_axi_araddr == OFF_TAG) begin
				s_axi_rdata <= {16'h0, tagWord};
			end else if (s_axi_araddr == OFF_SEL) begin
				s_axi_rdata <= {29'h0, sel_q};
			end else if (s_axi_araddr == OFF_DLO) begin
				s_axi_rdata <= fp.rdEntry[31:0];
			end else if (s_axi_araddr == OFF_DHI) begin
				s_axi_rdata <= fp.rdEntry[63:32];
			end else if (s_axi_araddr == OFF_EXP) begin
				s_axi_rdata <= {16'h0, fp.rdEntry[FP_BITS-1:REG_BITS]};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	top_zero_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && !fault |=> stackTop == TOP_ZERO) // [RULE_03]
		else $error("stack top not zero after instruction");
	tag_valid_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && !fault && instrOp != PSFA_OP_EMPTY |=> tagWord == TAG_VALID) // [RULE_05]
		else $error("tags not valid after instruction");
	tag_empty_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && !fault && instrOp == PSFA_OP_EMPTY |=> tagWord == TAG_EMPTY) // [RULE_06]
		else $error("tags not empty after empty-state instruction");
	no_numeric_a: assert property (@(posedge clk) disable iff (rst)
		excVector == VEC_NUMERIC |-> $past(pend_q)) // [RULE_07]
		else $error("numeric fault without pending error");
	pend_fault_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && pend_q && !emul_q && !memFault |=> excValid && excVector == VEC_NUMERIC && fpErrOut) // [RULE_08]
		else $error("pending error not reported");
	emul_fault_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && emul_q |=> excVector == VEC_INVALID && !doneValid) // [RULE_11]
		else $error("emulation bit did not give invalid opcode");
	mem_fault_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && memFault && !emul_q |=> excValid && excVector == $past(memFaultVec)) // [RULE_10]
		else $error("memory fault not reported");
	read_alias_a: assert property (@(posedge clk) disable iff (rst)
		instrValid && instrOp == PSFA_OP_WRITE && !fault ##1 instrValid && instrOp == PSFA_OP_READ
		&& instrReg == $past(instrReg) |=> rdData == $past(instrData, 2)) // [RULE_01] [RULE_02]
		else $error("read does not return aliased write");
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench for the packed simd / fp alias block
// Assumes: axi4-lite master tasks, pipeline model for instructions
// Notes:   expectations derived from package constants
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import psfa_pkg::*;
	logic clk, rst;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp;
	logic instrValid, memFault, doneValid, excValid, fpErrOut;
	psfa_op_type instrOp;
	logic [2:0] instrReg, stackTop;
	logic [63:0] instrData, rdData;
	logic [7:0] memFaultVec, excVector;
	logic [15:0] tagWord;
	int num_errors = 0, compares = 0, cycles = 0;
	psfa_regs i_psfa_regs (.clk(clk), .rst(rst), .instrValid(instrValid), .instrOp(instrOp),
		.instrReg(instrReg), .instrData(instrData), .memFault(memFault), .memFaultVec(memFaultVec),
		.doneValid(doneValid), .rdData(rdData), .excValid(excValid), .excVector(excVector),
		.fpErrOut(fpErrOut), .stackTop(stackTop), .tagWord(tagWord), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	psfa_pipe_model i_psfa_pipe_model (.clk(clk), .instrValid(instrValid), .instrOp(instrOp),
		.instrReg(instrReg), .instrData(instrData), .memFault(memFault), .memFaultVec(memFaultVec));
	////////////////////////////////////////////////////////////////
	// checks, bus tasks, verdict
	task automatic close_out;
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		rd = rdata;
		chk("rresp", er, rresp);
	endtask
	function automatic logic [63:0] pat(input int i);
		return 64'h0123456789abcdef + 64'(i) * 64'h1111000011110000;
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("tag reset", TAG_EMPTY, tagWord);
		for (int i = 0; i < NUM_REGS; i++) begin
			i_psfa_pipe_model.issue(PSFA_OP_WRITE, 3'(i), pat(i), 1'b0, 8'h0);
			chk("done", 1'b1, doneValid);
			chk("tag valid", TAG_VALID, tagWord);
			chk("top", TOP_ZERO, stackTop);
		end
		for (int i = 0; i < NUM_REGS; i++) begin
			i_psfa_pipe_model.issue(PSFA_OP_READ, 3'(i), 64'h0, 1'b0, 8'h0);
			chk("rdData", pat(i), rdData);
			axw(OFF_SEL, 32'(i), RESP_OKAY);
			axr(OFF_DLO, RESP_OKAY);
			chk("alias lo", pat(i) & 64'hffffffff, rd);
			axr(OFF_DHI, RESP_OKAY);
			chk("alias hi", pat(i) >> 32, rd);
			axr(OFF_EXP, RESP_OKAY);
			chk("exponent", EXP_ONES, rd[14:0]);
		end
		i_psfa_pipe_model.issue(PSFA_OP_EMPTY, 3'h0, 64'h0, 1'b0, 8'h0);
		chk("tag empty", TAG_EMPTY, tagWord);
		axr(OFF_TAG, RESP_OKAY);
		chk("tag reg", TAG_EMPTY, rd[15:0]);
		i_psfa_pipe_model.issue(PSFA_OP_OTHER, 3'h0, 64'h0, 1'b0, 8'h0);
		chk("tag other", TAG_VALID, tagWord);
		i_psfa_pipe_model.issue(PSFA_OP_WRITE, 3'h2, 64'h0, 1'b1, 8'h0e);
		chk("mem vec", 8'h0e, excVector);
		i_psfa_pipe_model.issue(PSFA_OP_READ, 3'h2, 64'h0, 1'b0, 8'h0);
		chk("no change", pat(2), rdData);
		axw(OFF_CTRL, 32'h2, RESP_OKAY);
		axr(OFF_STATUS, RESP_OKAY);
		chk("pending", 1'b1, rd[ST_PEND]);
		chk("status top", TOP_ZERO, rd[13:11]);
		i_psfa_pipe_model.issue(PSFA_OP_READ, 3'h5, 64'h0, 1'b0, 8'h0);
		chk("num vec", {1'b1, VEC_NUMERIC}, {excValid, excVector});
		chk("fp error", 1'b1, fpErrOut);
		axw(OFF_CTRL, 32'h0, RESP_OKAY);
		axr(OFF_STATUS, RESP_OKAY);
		chk("err clear", 2'b00, rd[ST_ERR:ST_PEND]);
		i_psfa_pipe_model.issue(PSFA_OP_READ, 3'h5, 64'h0, 1'b0, 8'h0);
		chk("restart done", 1'b1, doneValid);
		chk("restart data", pat(5), rdData);
		axw(OFF_CTRL, 32'h1, RESP_OKAY);
		i_psfa_pipe_model.issue(PSFA_OP_WRITE, 3'h1, 64'h0, 1'b1, 8'h0e);
		chk("invalid op", {1'b1, VEC_INVALID}, {excValid, excVector});
		axw(OFF_CTRL, 32'h0, RESP_OKAY);
		axw(8'h40, 32'h5, RESP_SLVERR);
		axr(8'h40, RESP_SLVERR);
		chk("unmapped", 32'h0, rd);
		i_psfa_pipe_model.issue_pair(3'h6, 64'h0f1e2d3c4b5a6978);
		chk("pair done", 1'b1, doneValid);
		chk("pair read", 64'h0f1e2d3c4b5a6978, rdData);
		axw(OFF_CTRL, 32'h2, RESP_OKAY);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("tag reset again", TAG_EMPTY, tagWord);
		axr(OFF_STATUS, RESP_OKAY);
		chk("pend reset", 2'b00, rd[ST_ERR:ST_PEND]);
		i_psfa_pipe_model.issue(PSFA_OP_READ, 3'h6, 64'h0, 1'b0, 8'h0);
		chk("no numeric", 1'b1, doneValid);
		i_psfa_pipe_model.issue(PSFA_OP_EMPTY, 3'h0, 64'h0, 1'b0, 8'h0);
		chk("tag final", TAG_EMPTY, tagWord);
		close_out();
	end
endmodule
`default_nettype wire
